// File: rtl/wol_lock_pkg.sv
// Constants, command codes and carrier types for the write-once security lock.
package security_lock_pkg;

   localparam int KEY_W = 32;
   localparam int MATCH_MIN = 28;
   // Key pattern value is arbitrary and stands in for the product key.
   localparam logic [31:0] KEY_PATTERN_DEFAULT = 32'h5A3C_96E1;
   localparam logic [31:0] ERASED_WORD = 32'h0000_0000;
   localparam int NUM_BLOCKS_DEFAULT = 4;
   localparam int WORDS_PER_BLOCK_DEFAULT = 8;
   localparam int IDX_W = 8;

   localparam int PROT_W = 2;
   localparam int PROT_NO_READ_BIT = 0;
   localparam int PROT_NO_WRITE_BIT = 1;
   localparam logic [1:0] PROT_OPEN = 2'h0;

   typedef enum logic [3:0] {
      OP_NONE        = 4'h0,
      OP_KEY_LOAD    = 4'h1,
      OP_KEY_PROGRAM = 4'h2,
      OP_KEY_READ    = 4'h3,
      OP_CHIP_ERASE  = 4'h4,
      OP_BLOCK_ERASE = 4'h5,
      OP_PROGRAM     = 4'h6,
      OP_VERIFY      = 4'h7,
      OP_PROT_RAISE  = 4'h8,
      OP_PROT_READ   = 4'h9
   } op_e;

   typedef enum logic [2:0] {
      KEY_EMPTY      = 3'b001,
      KEY_LOADED     = 3'b010,
      KEY_PROGRAMMED = 3'b100
   } key_stage_e;

   typedef struct packed {
      op_e op;
      logic via_swd;
      logic [IDX_W-1:0] block;
      logic [IDX_W-1:0] word;
      logic [31:0] data;
   } cmd_s;

   typedef struct packed {
      logic ok;
      logic match;
      logic [31:0] data;
   } rsp_s;

endpackage : security_lock_pkg

// File: rtl/write_once_security_lock.sv
// Write-once security latch with reset-sampled lockout and flash access control.
//
// Contract
// - The latch holds a four-byte key that the debug ports load and then program.
// - The lock output is high when at least 28 of the 32 stored bits match the key pattern.
// - A sampled lock turns off the test, programming and debug ports for good, except the latch read-out over SWD.
// - While locked, debug and test stay blocked and the latch can be neither erased nor altered.
// - Lockout needs, in order, a key load, a key program and then a device reset.
// - The lock output is sampled only during reset and gates access until the next reset.
// - A key load is accepted only while no block has any flash protection set.
// - After the key is loaded and programmed, access stays open until the next reset.
// - The latch value can be read out through the serial wire debug port.
// - Whole-device erase, program and verify work from either the JTAG or the SWD port.
// - Protection can be raised at any time while unlocked and is cleared only by a full device erase.
// - Block erase, program and verify are done only when that block's protection allows them.
`timescale 1ns/10ps
module write_once_security_lock
   import security_lock_pkg::*;
#(
   parameter int NUM_BLOCKS = NUM_BLOCKS_DEFAULT,
   parameter int WORDS_PER_BLOCK = WORDS_PER_BLOCK_DEFAULT,
   parameter logic [31:0] KEY_PATTERN = KEY_PATTERN_DEFAULT
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic req_valid_i,
   input wire cmd_s cmd_i,
   input wire logic [KEY_W-1:0] nv_key_i,
   output logic rsp_valid_o,
   output rsp_s rsp_o,
   output logic nv_prog_o,
   output logic [KEY_W-1:0] nv_wdata_o,
   output logic locked_o,
   output logic debug_enable_o,
   output logic test_enable_o,
   output logic prog_enable_o,
   output key_stage_e key_stage_o
);

   localparam int BW = (NUM_BLOCKS > 1) ? $clog2(NUM_BLOCKS) : 1;
   localparam int WW = (WORDS_PER_BLOCK > 1) ? $clog2(WORDS_PER_BLOCK) : 1;
   localparam logic [IDX_W-1:0] NUM_BLOCKS_IDX = IDX_W'(NUM_BLOCKS);
   localparam logic [IDX_W-1:0] WORDS_IDX = IDX_W'(WORDS_PER_BLOCK);

   ////////////////////////////////////////////////////////////////////////////////
   // Majority vote over the nonvolatile key bits.

   logic [KEY_W-1:0] bit_eq;
   logic [5:0] match_cnt;
   logic vote_match;

   genvar gi;
   generate
      for (gi = 0; gi < KEY_W; gi++) begin : g_eq
         assign bit_eq[gi] = (nv_key_i[gi] == KEY_PATTERN[gi]);
      end
   endgenerate

   always_comb begin
      match_cnt = 6'h00;
      for (int i = 0; i < KEY_W; i++) begin
         match_cnt = match_cnt + {5'h00, bit_eq[i]};
      end
      vote_match = (match_cnt >= 6'(MATCH_MIN));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reset-sampled lock and port gating.

   logic locked_r;
   logic locked_nxt;
   logic debug_enable_r;
   logic debug_enable_nxt;

   always_comb begin
      locked_nxt = locked_r;
      if (!resetn_i) begin
         locked_nxt = vote_match;
      end
      debug_enable_nxt = !locked_nxt;
   end

   always_ff @(posedge clk_i) begin
      locked_r <= locked_nxt;
      debug_enable_r <= debug_enable_nxt;
   end

   assign locked_o = locked_r;
   assign debug_enable_o = debug_enable_r;
   assign test_enable_o = debug_enable_r;
   assign prog_enable_o = debug_enable_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Flash contents and per-block protection, kept over reset as nonvolatile state.

   logic [31:0] flash_r [NUM_BLOCKS][WORDS_PER_BLOCK];
   logic [31:0] flash_nxt [NUM_BLOCKS][WORDS_PER_BLOCK];
   logic [PROT_W-1:0] prot_r [NUM_BLOCKS];
   logic [PROT_W-1:0] prot_nxt [NUM_BLOCKS];

   ////////////////////////////////////////////////////////////////////////////////
   // Command handling.

   key_stage_e stage_r;
   key_stage_e stage_nxt;
   logic [KEY_W-1:0] vol_key_r;
   logic [KEY_W-1:0] vol_key_nxt;
   logic rsp_valid_r;
   logic rsp_valid_nxt;
   rsp_s rsp_r;
   rsp_s rsp_nxt;
   logic nv_prog_r;
   logic nv_prog_nxt;
   logic [KEY_W-1:0] nv_wdata_r;
   logic [KEY_W-1:0] nv_wdata_nxt;

   logic any_prot;
   logic addr_ok;
   logic blk_ok;
   logic [BW-1:0] blk;
   logic [WW-1:0] wrd;
   logic [PROT_W-1:0] cur_prot;
   logic [PROT_W-1:0] new_prot;

   always_comb begin
      flash_nxt = flash_r;
      prot_nxt = prot_r;
      stage_nxt = stage_r;
      vol_key_nxt = vol_key_r;
      rsp_valid_nxt = 1'b0;
      rsp_nxt = '0;
      nv_prog_nxt = 1'b0;
      nv_wdata_nxt = nv_wdata_r;
      blk = cmd_i.block[BW-1:0];
      wrd = cmd_i.word[WW-1:0];
      blk_ok = (cmd_i.block < NUM_BLOCKS_IDX);
      addr_ok = blk_ok && (cmd_i.word < WORDS_IDX);
      cur_prot = blk_ok ? prot_r[blk] : PROT_OPEN;
      new_prot = cmd_i.data[PROT_W-1:0];
      any_prot = 1'b0;
      for (int b = 0; b < NUM_BLOCKS; b++) begin
         any_prot = any_prot | (prot_r[b] != PROT_OPEN);
      end
      if (!resetn_i) begin
         stage_nxt = KEY_EMPTY;
         vol_key_nxt = '0;
         nv_wdata_nxt = '0;
      end else if (req_valid_i) begin
         rsp_valid_nxt = 1'b1;
         if (locked_r) begin
            // Only the latch read-out over SWD survives a lock.
            if (cmd_i.op == OP_KEY_READ && cmd_i.via_swd) begin
               rsp_nxt.ok = 1'b1;
               rsp_nxt.data = nv_key_i;
            end
         end else begin
            // Both debug ports reach the same operations, except the latch read-out, which answers over SWD only.
            unique case (cmd_i.op)
               OP_KEY_LOAD: begin
                  if (!any_prot && !vote_match) begin
                     vol_key_nxt = cmd_i.data;
                     stage_nxt = KEY_LOADED;
                     rsp_nxt.ok = 1'b1;
                  end
               end
               OP_KEY_PROGRAM: begin
                  // A latch that already votes locked is frozen.
                  if (stage_r == KEY_LOADED && !vote_match) begin
                     nv_prog_nxt = 1'b1;
                     nv_wdata_nxt = vol_key_r;
                     stage_nxt = KEY_PROGRAMMED;
                     rsp_nxt.ok = 1'b1;
                  end
               end
               OP_KEY_READ: begin
                  if (cmd_i.via_swd) begin
                     rsp_nxt.ok = 1'b1;
                     rsp_nxt.data = nv_key_i;
                  end
               end
               OP_CHIP_ERASE: begin
                  for (int b = 0; b < NUM_BLOCKS; b++) begin
                     prot_nxt[b] = PROT_OPEN;
                     for (int w = 0; w < WORDS_PER_BLOCK; w++) begin
                        flash_nxt[b][w] = ERASED_WORD;
                     end
                  end
                  rsp_nxt.ok = 1'b1;
               end
               OP_BLOCK_ERASE: begin
                  if (blk_ok && !cur_prot[PROT_NO_WRITE_BIT]) begin
                     for (int w = 0; w < WORDS_PER_BLOCK; w++) begin
                        flash_nxt[blk][w] = ERASED_WORD;
                     end
                     rsp_nxt.ok = 1'b1;
                  end
               end
               OP_PROGRAM: begin
                  if (addr_ok && !cur_prot[PROT_NO_WRITE_BIT]) begin
                     flash_nxt[blk][wrd] = cmd_i.data;
                     rsp_nxt.ok = 1'b1;
                  end
               end
               OP_VERIFY: begin
                  if (addr_ok && !cur_prot[PROT_NO_READ_BIT]) begin
                     rsp_nxt.ok = 1'b1;
                     rsp_nxt.match = (flash_r[blk][wrd] == cmd_i.data);
                     rsp_nxt.data = flash_r[blk][wrd];
                  end
               end
               OP_PROT_RAISE: begin
                  // Any bit already set must stay set, so a level only rises.
                  if (blk_ok && ((new_prot & cur_prot) == cur_prot)) begin
                     prot_nxt[blk] = new_prot;
                     rsp_nxt.ok = 1'b1;
                  end
               end
               OP_PROT_READ: begin
                  if (blk_ok) begin
                     rsp_nxt.ok = 1'b1;
                     rsp_nxt.data = {{(32-PROT_W){1'b0}}, cur_prot};
                  end
               end
               default: begin
                  rsp_nxt.ok = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      flash_r <= flash_nxt;
      prot_r <= prot_nxt;
      stage_r <= stage_nxt;
      vol_key_r <= vol_key_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_r <= rsp_nxt;
      nv_prog_r <= nv_prog_nxt;
      nv_wdata_r <= nv_wdata_nxt;
   end

   assign rsp_valid_o = rsp_valid_r;
   assign rsp_o = rsp_r;
   assign nv_prog_o = nv_prog_r;
   assign nv_wdata_o = nv_wdata_r;
   assign key_stage_o = stage_r;

endmodule : write_once_security_lock

// File: verif/nv_cell_model.sv
// Behavioural model of the external nonvolatile key cells.
`timescale 1ns/10ps
module nv_cell_model
   import security_lock_pkg::*;
(
   input wire logic clk_i,
   input wire logic nv_prog_i,
   input wire logic [KEY_W-1:0] nv_wdata_i,
   output logic [KEY_W-1:0] nv_key_o
);
   initial nv_key_o = ~KEY_PATTERN_DEFAULT;
   always @(posedge clk_i) begin
      if (nv_prog_i) begin
         nv_key_o <= nv_wdata_i;
      end
   end
endmodule : nv_cell_model

// File: verif/wol_lock_chk.sv
// Assertion checker for the write-once security lock.
`timescale 1ns/10ps
module security_lock_chk
   import security_lock_pkg::*;
#(
   parameter logic [31:0] KEY_PATTERN = KEY_PATTERN_DEFAULT
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic req_valid_i,
   input wire cmd_s cmd_i,
   input wire logic [KEY_W-1:0] nv_key_i,
   input wire logic rsp_valid_o,
   input wire rsp_s rsp_o,
   input wire logic nv_prog_o,
   input wire logic locked_o,
   input wire logic debug_enable_o,
   input wire logic test_enable_o,
   input wire logic prog_enable_o,
   input wire key_stage_e key_stage_o
);
   logic vote;
   assign vote = $countones(~(nv_key_i ^ KEY_PATTERN)) >= MATCH_MIN;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_key_prog;
      req_valid_i && cmd_i.op == OP_KEY_PROGRAM && key_stage_o == KEY_LOADED && !locked_o && !vote;
   endsequence
   a_rsp_one_cycle:
   assert property (req_valid_i |=> rsp_valid_o) else $error("answer missing");
   a_no_spur_rsp:
   assert property (!req_valid_i |=> !rsp_valid_o) else $error("answer without request");
   a_lock_vote:
   assert property ($rose(resetn_i) |-> locked_o == $past(vote)) else $error("lock vote wrong");
   a_lock_hold:
   assert property ($past(resetn_i) |-> $stable({locked_o, debug_enable_o}))
      else $error("lock changed");
   a_ports_gated:
   assert property (debug_enable_o == !locked_o && test_enable_o == !locked_o
      && prog_enable_o == !locked_o) else $error("port gating wrong");
   a_locked_refuse:
   assert property (req_valid_i && locked_o && !(cmd_i.op == OP_KEY_READ && cmd_i.via_swd)
      |=> rsp_valid_o && !rsp_o.ok) else $error("locked access taken");
   a_jtag_read_refused:
   assert property (req_valid_i && cmd_i.op == OP_KEY_READ && !cmd_i.via_swd |=> !rsp_o.ok)
      else $error("key read on wrong port");
   a_key_prog_done:
   assert property (s_key_prog |=> nv_prog_o && rsp_o.ok && key_stage_o == KEY_PROGRAMMED)
      else $error("key program failed");
   a_prog_cause:
   assert property (nv_prog_o |-> $past(req_valid_i) && $past(cmd_i.op) == OP_KEY_PROGRAM)
      else $error("stray program pulse");
endmodule : security_lock_chk
bind write_once_security_lock security_lock_chk #(.KEY_PATTERN(KEY_PATTERN)) u_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .cmd_i(cmd_i),
   .nv_key_i(nv_key_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .nv_prog_o(nv_prog_o),
   .locked_o(locked_o), .debug_enable_o(debug_enable_o), .test_enable_o(test_enable_o),
   .prog_enable_o(prog_enable_o), .key_stage_o(key_stage_o));

// File: verif/write_once_security_lock_test.sv
// Self-checking testbench for the write-once security lock.
`timescale 1ns/10ps
module write_once_security_lock_test
   import security_lock_pkg::*;
;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req_valid_i = 1'b0;
   cmd_s cmd_i = '0;
   logic [KEY_W-1:0] nv_key, nv_wdata_o;
   logic rsp_valid_o, nv_prog_o, locked_o, debug_enable_o, test_enable_o, prog_enable_o;
   rsp_s rsp_o;
   key_stage_e key_stage_o;
   int n_errors = 0;
   int checked = 0;
   write_once_security_lock DUT (.clk_i(clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i),
      .cmd_i(cmd_i), .nv_key_i(nv_key), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
      .nv_prog_o(nv_prog_o), .nv_wdata_o(nv_wdata_o), .locked_o(locked_o),
      .debug_enable_o(debug_enable_o), .test_enable_o(test_enable_o),
      .prog_enable_o(prog_enable_o), .key_stage_o(key_stage_o));
   nv_cell_model u_nv (.clk_i(clk_i), .nv_prog_i(nv_prog_o), .nv_wdata_i(nv_wdata_o),
      .nv_key_o(nv_key));
   initial forever #25 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_val(logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : final_report
   task automatic do_reset(int n);
      @(negedge clk_i);
      resetn_i = 1'b0;
      repeat (n) @(negedge clk_i);
      resetn_i = 1'b1;
   endtask : do_reset
   task automatic ex(op_e op, logic swd, logic [7:0] blk, logic [31:0] d, logic ok,
      logic [31:0] q);
      @(negedge clk_i);
      req_valid_i = 1'b1;
      cmd_i = '{op, swd, blk, 8'h00, d};
      @(negedge clk_i);
      req_valid_i = 1'b0;
      chk_val(rsp_valid_o, 1'b1);
      chk_val(rsp_o.ok, ok);
      if (!ok || op inside {OP_VERIFY, OP_KEY_READ, OP_PROT_READ}) begin
         chk_val(rsp_o.data, q);
      end
      if (ok && op == OP_VERIFY) begin
         chk_val(rsp_o.match, q == d);
      end
   endtask : ex
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_flash();
      ex(OP_CHIP_ERASE, 1'b0, 8'h00, 0, 1'b1, 0);
      ex(OP_PROGRAM, 1'b1, 8'h00, 32'hA5A5_0F0F, 1'b1, 0);
      ex(OP_VERIFY, 1'b0, 8'h00, 32'hA5A5_0F0F, 1'b1, 32'hA5A5_0F0F);
      ex(OP_BLOCK_ERASE, 1'b1, 8'h00, 0, 1'b1, 0);
      ex(OP_VERIFY, 1'b1, 8'h00, 32'hA5A5_0F0F, 1'b1, 0);
      ex(OP_PROGRAM, 1'b0, 8'h04, 0, 1'b0, 0);
      ex(OP_KEY_PROGRAM, 1'b1, 8'h00, 0, 1'b0, 0);
   endtask : t_flash
   task automatic t_prot();
      ex(OP_PROT_RAISE, 1'b0, 8'h01, 32'h0000_0002, 1'b1, 0);
      ex(OP_PROGRAM, 1'b1, 8'h01, 32'h1234_5678, 1'b0, 0);
      ex(OP_VERIFY, 1'b1, 8'h01, 0, 1'b1, 0);
      ex(OP_PROT_RAISE, 1'b0, 8'h01, 32'h0000_0001, 1'b0, 0);
      ex(OP_PROT_READ, 1'b1, 8'h01, 0, 1'b1, 32'h0000_0002);
      ex(OP_PROT_RAISE, 1'b1, 8'h02, 32'h0000_0001, 1'b1, 0);
      ex(OP_VERIFY, 1'b0, 8'h02, 0, 1'b0, 0);
      ex(OP_KEY_LOAD, 1'b1, 8'h00, KEY_PATTERN_DEFAULT, 1'b0, 0);
      ex(OP_CHIP_ERASE, 1'b1, 8'h00, 0, 1'b1, 0);
      ex(OP_PROT_READ, 1'b0, 8'h01, 0, 1'b1, 0);
   endtask : t_prot
   task automatic t_lock(logic [31:0] key, logic lk);
      ex(OP_KEY_LOAD, 1'b1, 8'h00, key, 1'b1, 0);
      chk_val(key_stage_o, KEY_LOADED);
      ex(OP_KEY_PROGRAM, 1'b0, 8'h00, 0, 1'b1, 0);
      chk_val({nv_prog_o, key_stage_o}, {1'b1, KEY_PROGRAMMED});
      chk_val(nv_wdata_o, key);
      ex(OP_VERIFY, 1'b0, 8'h01, 0, 1'b1, 0);
      do_reset(2);
      chk_val({locked_o, debug_enable_o, test_enable_o, prog_enable_o}, lk ? 8 : 7);
      ex(OP_PROGRAM, 1'b0, 8'h00, 32'h0000_0001, !lk, 0);
      ex(OP_KEY_LOAD, 1'b1, 8'h00, 0, !lk, 0);
      ex(OP_KEY_READ, 1'b1, 8'h00, 0, 1'b1, key);
      ex(OP_KEY_READ, 1'b0, 8'h00, 0, 1'b0, 0);
   endtask : t_lock
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
   initial begin
      do_reset(20);
      t_flash();
      t_prot();
      t_lock(KEY_PATTERN_DEFAULT ^ 32'h0000_001F, 1'b0);
      t_lock(KEY_PATTERN_DEFAULT ^ 32'h0000_000F, 1'b1);
      final_report();
   end
endmodule : write_once_security_lock_test
